//--- verilog/set_timers.sv
// sensor engine timer group: two basic timers and a four-channel capture/compare timer
`timescale 1ns/1ps
module set_timers
   import set_pkg::*;
(
   input  wire logic                      CLK,
   input  wire logic                      RST,
   input  wire logic [NUM_BT-1:0]         BT_START,
   input  wire logic [NUM_BT-1:0]         BT_STOP,
   input  wire logic [NUM_BT-1:0]         BT_PERIODIC,
   input  wire logic [NUM_BT-1:0]         BT_EDGE_MODE,
   input  wire logic [NUM_BT-1:0]         BT_TICK_IN,
   input  wire logic [NUM_BT*PRE_W-1:0]   BT_PRESCALE,
   input  wire logic [NUM_BT*CNT_W-1:0]   BT_TARGET,
   output logic      [NUM_BT*CNT_W-1:0]   BT_COUNT,
   output logic      [NUM_BT-1:0]         BT_EVENT,
   output logic      [NUM_BT-1:0]         BT_RUNNING,
   input  wire logic                      T2_START,
   input  wire logic                      T2_STOP,
   input  wire logic                      T2_PERIODIC,
   input  wire logic [1:0]                T2_RATE_SEL,
   input  wire logic [CNT_W-1:0]          T2_TARGET,
   output logic      [CNT_W-1:0]          T2_COUNT,
   output logic                           T2_RUNNING,
   output logic                           T2_EVENT,
   input  wire logic [NUM_CH-1:0]         CH_CAPTURE_MODE,
   input  wire logic [NUM_CH-1:0]         CH_PERIODIC,
   input  wire logic [NUM_CH-1:0]         CH_ARM,
   input  wire logic [NUM_CH*CNT_W-1:0]   CH_COMPARE,
   input  wire logic [NUM_CH-1:0]         CH_CAP_IN,
   input  wire logic [NUM_CH-1:0]         CH_ADC_SEL,
   output logic      [NUM_CH-1:0]         CH_EVENT,
   output logic      [NUM_CH*CNT_W-1:0]   CH_CAPTURED,
   output logic      [NUM_CH-1:0]         CH_PWM,
   output logic                           ADC_TRIGGER
);
   // two identical basic timers
   for (genvar b = 0; b < NUM_BT; b++) begin : g_bt
      set_basic_timer u_bt (
         .clk       (CLK),
         .rst       (RST),
         .start     (BT_START[b]),
         .stop      (BT_STOP[b]),
         .periodic  (BT_PERIODIC[b]),
         .edge_mode (BT_EDGE_MODE[b]),
         .tick_in   (BT_TICK_IN[b]),
         .prescale  (BT_PRESCALE[b*PRE_W +: PRE_W]),
         .target    (BT_TARGET[b*CNT_W +: CNT_W]),
         .count     (BT_COUNT[b*CNT_W +: CNT_W]),
         .event_out (BT_EVENT[b]),
         .running   (BT_RUNNING[b])
      );
   end

   function automatic logic [ACC_W-1:0] rate_inc(input logic [1:0] sel);
      unique case (sel)
         SEL_24M: rate_inc = ACC_24M;
         SEL_2M:  rate_inc = ACC_2M;
         default: rate_inc = ACC_32K;
      endcase
   endfunction

   logic [ACC_W-1:0]        acc_reg, acc_next, sum;
   logic                    tick_reg, tick_next;
   logic [CNT_W-1:0]        cnt_reg, cnt_next;
   logic                    run_reg, run_next;
   logic                    tev_reg, tev_next;
   logic                    adv;
   logic [NUM_CH-1:0]       cs0_reg, cs1_reg, cs2_reg, clvl_reg, clvl_next, rise;
   logic [NUM_CH-1:0]       armed_reg, armed_next;
   logic [NUM_CH-1:0]       cev_reg, cev_next;
   logic [NUM_CH-1:0]       pwm_reg, pwm_next;
   logic [NUM_CH*CNT_W-1:0] cap_reg, cap_next;
   logic                    adc_reg, adc_next;

   // rate generator and third counter; its own start/stop only, so it keeps
   // running whatever the sensor processor is doing
   always_comb begin
      // fractional accumulator: ticks average the chosen rate, at the cost of
      // a jitter of one system clock between ticks
      sum       = ACC_W'(acc_reg + rate_inc(T2_RATE_SEL));
      tick_next = (sum >= ACC_CLK);
      acc_next  = tick_next ? ACC_W'(sum - ACC_CLK) : sum;
      adv       = run_reg && tick_reg;
      cnt_next  = cnt_reg;
      run_next  = run_reg;
      tev_next  = 1'b0;
      if (T2_START) begin
         cnt_next = CNT_START;
         run_next = 1'b1;
      end else if (T2_STOP) begin
         run_next = 1'b0;
      end else if (adv) begin
         if (cnt_reg == T2_TARGET) begin
            tev_next = 1'b1;
            if (T2_PERIODIC) begin
               cnt_next = CNT_START;
            end else begin
               run_next = 1'b0;
            end
         end else begin
            cnt_next = set_count_step(cnt_reg, T2_TARGET);
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         acc_reg  <= '0;
         tick_reg <= 1'b0;
         cnt_reg  <= CNT_START;
         run_reg  <= 1'b0;
         tev_reg  <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         tick_reg <= tick_next;
         cnt_reg  <= cnt_next;
         run_reg  <= run_next;
         tev_reg  <= tev_next;
      end
   end

   // capture/compare channels
   always_comb begin
      clvl_next  = clvl_reg;
      armed_next = armed_reg;
      cev_next   = '0;
      pwm_next   = '0;
      cap_next   = cap_reg;
      rise       = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         rise[i] = (cs2_reg[i] == cs1_reg[i]) && cs1_reg[i] && !clvl_reg[i];
         if (cs2_reg[i] == cs1_reg[i]) begin
            clvl_next[i] = cs1_reg[i];
         end
         if (CH_CAPTURE_MODE[i]) begin
            if (rise[i] && armed_reg[i]) begin
               cap_next[i*CNT_W +: CNT_W] = cnt_reg;
               cev_next[i] = 1'b1;
               armed_next[i] = CH_PERIODIC[i];
            end
         end else begin
            if (adv && cnt_reg == CH_COMPARE[i*CNT_W +: CNT_W] && armed_reg[i]) begin
               cev_next[i] = 1'b1;
               armed_next[i] = CH_PERIODIC[i];
            end
            pwm_next[i] = run_reg && (cnt_reg < CH_COMPARE[i*CNT_W +: CNT_W]);
         end
         // arming wins over a disarm in the same cycle
         if (CH_ARM[i] || T2_START) begin
            armed_next[i] = 1'b1;
         end
      end
      adc_next = |(cev_next & CH_ADC_SEL);
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cs0_reg   <= '0;
         cs1_reg   <= '0;
         cs2_reg   <= '0;
         clvl_reg  <= '0;
         armed_reg <= '0;
         cev_reg   <= '0;
         pwm_reg   <= '0;
         cap_reg   <= '0;
         adc_reg   <= 1'b0;
      end else begin
         cs0_reg   <= CH_CAP_IN;
         cs1_reg   <= cs0_reg;
         cs2_reg   <= cs1_reg;
         clvl_reg  <= clvl_next;
         armed_reg <= armed_next;
         cev_reg   <= cev_next;
         pwm_reg   <= pwm_next;
         cap_reg   <= cap_next;
         adc_reg   <= adc_next;
      end
   end

   assign T2_COUNT    = cnt_reg;
   assign T2_RUNNING  = run_reg;
   assign T2_EVENT    = tev_reg;
   assign CH_EVENT    = cev_reg;
   assign CH_CAPTURED = cap_reg;
   assign CH_PWM      = pwm_reg;
   assign ADC_TRIGGER = adc_reg;

   sequence s_t2_end;
      adv && cnt_reg == T2_TARGET && !T2_START && !T2_STOP;
   endsequence

   property p_t2_wrap;
      @(posedge CLK) disable iff (RST)
      s_t2_end and T2_PERIODIC |=> cnt_reg == CNT_START && tev_reg && run_reg;
   endproperty
   a_t2_wrap: assert property (p_t2_wrap) else $error("periodic third timer did not restart");

   property p_t2_oneshot;
      @(posedge CLK) disable iff (RST)
      s_t2_end and !T2_PERIODIC |=> !run_reg && tev_reg ##1 !tev_reg;
   endproperty
   a_t2_oneshot: assert property (p_t2_oneshot) else $error("one-shot third timer did not stop once");

   property p_t2_adv;
      @(posedge CLK) disable iff (RST)
      adv && cnt_reg != T2_TARGET && !T2_START && !T2_STOP |=> cnt_reg == CNT_W'($past(cnt_reg) + 1'b1);
   endproperty
   a_t2_adv: assert property (p_t2_adv) else $error("third timer missed an advance");

   property p_rate_2m;
      @(posedge CLK) disable iff (RST)
      tick_reg && T2_RATE_SEL == SEL_2M |=> (!tick_reg || T2_RATE_SEL != SEL_2M)[*8];
   endproperty
   a_rate_2m: assert property (p_rate_2m) else $error("2 MHz tick came too early");

   property p_adc;
      @(posedge CLK) disable iff (RST)
      (|(cev_next & CH_ADC_SEL)) |=> ADC_TRIGGER ##1 (ADC_TRIGGER == |(cev_reg & $past(CH_ADC_SEL)));
   endproperty
   a_adc: assert property (p_adc) else $error("selected channel event gave no ADC trigger");

   for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
      property p_cmp;
         @(posedge CLK) disable iff (RST)
         !CH_CAPTURE_MODE[c] && adv && armed_reg[c] && cnt_reg == CH_COMPARE[c*CNT_W +: CNT_W]
            |=> CH_EVENT[c];
      endproperty
      a_cmp: assert property (p_cmp) else $error("compare match gave no channel event");

      property p_once;
         @(posedge CLK) disable iff (RST)
         cev_next[c] && !CH_PERIODIC[c] && !CH_ARM[c] && !T2_START |=> !armed_reg[c];
      endproperty
      a_once: assert property (p_once) else $error("one-shot channel stayed armed");

      property p_cap;
         @(posedge CLK) disable iff (RST)
         CH_CAPTURE_MODE[c] && rise[c] && armed_reg[c]
            |=> CH_EVENT[c] && CH_CAPTURED[c*CNT_W +: CNT_W] == $past(cnt_reg);
      endproperty
      a_cap: assert property (p_cap) else $error("capture edge did not store the count");

      property p_pwm;
         @(posedge CLK) disable iff (RST)
         !CH_CAPTURE_MODE[c] |=> CH_PWM[c] == ($past(run_reg) && $past(cnt_reg) < $past(CH_COMPARE[c*CNT_W +: CNT_W]));
      endproperty
      a_pwm: assert property (p_pwm) else $error("PWM level disagrees with count and compare");
   end
endmodule // set_timers

//--- verilog/set_pkg.sv
// shared constants and helpers for the sensor engine timer group
package set_pkg;
   localparam int CNT_W     = 16;
   localparam int PRE_W     = 4;
   localparam int PRE_CNT_W = 15;
   localparam int NUM_BT    = 2;
   localparam int NUM_CH    = 4;
   localparam int ACC_W     = 26;

   localparam int CLK_HZ      = 40_000_000;
   localparam int RATE_24M_HZ = 24_000_000;
   localparam int RATE_2M_HZ  = 2_000_000;
   localparam int RATE_32K_HZ = 32_000;

   localparam logic [ACC_W-1:0] ACC_CLK = ACC_W'(CLK_HZ);
   localparam logic [ACC_W-1:0] ACC_24M = ACC_W'(RATE_24M_HZ);
   localparam logic [ACC_W-1:0] ACC_2M  = ACC_W'(RATE_2M_HZ);
   localparam logic [ACC_W-1:0] ACC_32K = ACC_W'(RATE_32K_HZ);

   localparam logic [1:0] SEL_24M = 2'h0;
   localparam logic [1:0] SEL_2M  = 2'h1;
   localparam logic [1:0] SEL_32K = 2'h2;

   localparam logic [CNT_W-1:0] CNT_START = 16'h0000;

   // count after one advance: wraps to the start value at the terminal count
   function automatic logic [CNT_W-1:0] set_count_step(input logic [CNT_W-1:0] c,
                                                         input logic [CNT_W-1:0] t);
      set_count_step = (c == t) ? CNT_START : CNT_W'(c + 1'b1);
   endfunction
endpackage

//--- verilog/set_basic_timer.sv
// basic prescaled 16-bit timer with clock or tick-edge counting
`timescale 1ns/1ps
module set_basic_timer
   import set_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             start,
   input  wire logic             stop,
   input  wire logic             periodic,
   input  wire logic             edge_mode,
   input  wire logic             tick_in,
   input  wire logic [PRE_W-1:0] prescale,
   input  wire logic [CNT_W-1:0] target,
   output logic      [CNT_W-1:0] count,
   output logic                  event_out,
   output logic                  running
);
   logic [2:0]           sync_reg, sync_next;
   logic                 lvl_reg, lvl_next;
   logic [PRE_CNT_W-1:0] pre_reg, pre_next, mask;
   logic [CNT_W-1:0]     count_reg, count_next;
   logic                 run_reg, run_next;
   logic                 event_reg, event_next;
   logic                 edge_seen, src, pre_done;

   always_comb begin
      sync_next  = {sync_reg[1:0], tick_in};
      // a tick change counts only once the second and third stages agree
      edge_seen  = (sync_reg[2] == sync_reg[1]) && (sync_reg[1] != lvl_reg);
      lvl_next   = (sync_reg[2] == sync_reg[1]) ? sync_reg[1] : lvl_reg;
      src        = edge_mode ? edge_seen : 1'b1;
      mask       = ~({PRE_CNT_W{1'b1}} << prescale);
      pre_done   = src && ((pre_reg & mask) == mask);
      pre_next   = pre_reg;
      count_next = count_reg;
      run_next   = run_reg;
      event_next = 1'b0;
      if (start) begin
         count_next = CNT_START;
         pre_next   = '0;
         run_next   = 1'b1;
      end else if (stop) begin
         run_next = 1'b0;
      end else if (run_reg && src) begin
         if (pre_done) begin
            pre_next = '0;
            if (count_reg == target) begin
               event_next = 1'b1;
               if (periodic) begin
                  count_next = CNT_START;
               end else begin
                  run_next = 1'b0;
               end
            end else begin
               count_next = set_count_step(count_reg, target);
            end
         end else begin
            pre_next = PRE_CNT_W'(pre_reg + 1'b1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_reg  <= '0;
         lvl_reg   <= 1'b0;
         pre_reg   <= '0;
         count_reg <= CNT_START;
         run_reg   <= 1'b0;
         event_reg <= 1'b0;
      end else begin
         sync_reg  <= sync_next;
         lvl_reg   <= lvl_next;
         pre_reg   <= pre_next;
         count_reg <= count_next;
         run_reg   <= run_next;
         event_reg <= event_next;
      end
   end

   assign count     = count_reg;
   assign event_out = event_reg;
   assign running   = run_reg;

   property p_bt_oneshot;
      @(posedge clk) disable iff (rst)
      run_reg && !periodic && pre_done && count_reg == target && !start && !stop |=> !run_reg && event_reg;
   endproperty
   a_bt_oneshot: assert property (p_bt_oneshot) else $error("one-shot basic timer did not stop");

   property p_bt_noedge;
      @(posedge clk) disable iff (rst)
      edge_mode && !edge_seen && !start |=> count_reg == $past(count_reg);
   endproperty
   a_bt_noedge: assert property (p_bt_noedge) else $error("basic timer moved without a tick edge");

   property p_bt_div1;
      @(posedge clk) disable iff (rst)
      run_reg && !edge_mode && prescale == '0 && count_reg != target && !start && !stop
         |=> count_reg == CNT_W'($past(count_reg) + 1'b1);
   endproperty
   a_bt_div1: assert property (p_bt_div1) else $error("undivided basic timer missed a count");
endmodule // set_basic_timer

//--- testbench/set_sensor_model.sv
// far-side model: sensor processor tick source, capture pins and adc trigger counter
`timescale 1ns/1ps
module set_sensor_model
   import set_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              adc_trigger,
   output logic      [NUM_BT-1:0] tick_out,
   output logic      [NUM_CH-1:0] cap_out
);
   int adc_hits = 0;
   initial begin
      tick_out = '0;
      cap_out  = '0;
   end
   always @(posedge clk) begin
      if (adc_trigger === 1'b1)
         adc_hits++;
   end
   // levels held 4 cycles so the 3-flop synchroniser sees them stable
   task automatic toggle_tick(input int b, input int n);
      repeat (n) begin
         @(posedge clk);
         tick_out[b] <= ~tick_out[b];
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic pulse_cap(input int ch);
      @(posedge clk);
      cap_out[ch] <= 1'b1;
      repeat (4) @(posedge clk);
      cap_out[ch] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule // set_sensor_model

//--- testbench/tb_sensor_engine_timers.sv
// self-checking bench for the sensor engine timer group
`timescale 1ns/1ps
module tb_sensor_engine_timers;
   import set_pkg::*;
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   logic [NUM_BT-1:0]       bt_start = '0, bt_stop = '0, bt_per = 2'h2, bt_edge = 2'h2, bt_event, bt_run;
   logic [NUM_BT*PRE_W-1:0] bt_pre = '0;
   logic [NUM_BT*CNT_W-1:0] bt_tgt = 32'h0064_0002, bt_count;
   logic                    t2_start = 1'b0, t2_stop = 1'b0, t2_per = 1'b0, t2_run, t2_event, adc_trig;
   logic [1:0]              t2_sel = 2'h0;
   logic [CNT_W-1:0]        t2_tgt = 16'h0000, t2_count;
   logic [NUM_CH-1:0]       ch_capm = 4'hE, ch_per = 4'h0, ch_arm = 4'h0, ch_adc = 4'h0, ch_event, ch_pwm;
   logic [NUM_CH*CNT_W-1:0] ch_cmp = '0, ch_capd;
   wire  [NUM_BT-1:0]       bt_tick;
   wire  [NUM_CH-1:0]       ch_cap;
   int                      n_errors = 0, cmp_count = 0, cycles = 0;

   always #12.5 clk = ~clk;

   set_timers u_dut (.CLK(clk), .RST(rst), .BT_START(bt_start), .BT_STOP(bt_stop), .BT_PERIODIC(bt_per),
      .BT_EDGE_MODE(bt_edge), .BT_TICK_IN(bt_tick), .BT_PRESCALE(bt_pre), .BT_TARGET(bt_tgt),
      .BT_COUNT(bt_count), .BT_EVENT(bt_event), .BT_RUNNING(bt_run), .T2_START(t2_start), .T2_STOP(t2_stop),
      .T2_PERIODIC(t2_per), .T2_RATE_SEL(t2_sel), .T2_TARGET(t2_tgt), .T2_COUNT(t2_count), .T2_RUNNING(t2_run),
      .T2_EVENT(t2_event), .CH_CAPTURE_MODE(ch_capm), .CH_PERIODIC(ch_per), .CH_ARM(ch_arm),
      .CH_COMPARE(ch_cmp), .CH_CAP_IN(ch_cap), .CH_ADC_SEL(ch_adc), .CH_EVENT(ch_event),
      .CH_CAPTURED(ch_capd), .CH_PWM(ch_pwm), .ADC_TRIGGER(adc_trig));
   set_sensor_model u_far (.clk(clk), .adc_trigger(adc_trig), .tick_out(bt_tick), .cap_out(ch_cap));

   task automatic test_done();
      if (n_errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ceiling sized for about 5000 cycles of tests
   always @(posedge clk) begin
      cycles++;
      if (cycles == 15000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   function automatic logic hit(input int w);
      if (w < 2)
         return bt_event[w];
      if (w == 2)
         return t2_event;
      return ch_event[w-3];
   endfunction
   // n counts falling edges up to the pulse; n == lim means none seen
   task automatic wait_ev(input int w, input int lim, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (hit(w) !== 1'b1 && n < lim);
   endtask

   task automatic t_oneshot();
      @(posedge clk);
      bt_start <= 2'h1;
      @(posedge clk);
      bt_start <= 2'h0;
      @(negedge clk);
      cmp("bt0 running", 16'h1, bt_run[0]);
      cmp("bt0 count", 16'h0, bt_count[15:0]);
      repeat (3) @(negedge clk);
      cmp("bt0 count", 16'h2, bt_count[15:0]);
      cmp("bt0 event", 16'h1, bt_event[0]);
      cmp("bt0 running", 16'h0, bt_run[0]);
      @(negedge clk);
      cmp("bt0 event", 16'h0, bt_event[0]);
   endtask
   task automatic t_periodic();
      int          n;
      logic [15:0] held;
      @(posedge clk);
      bt_per[0] <= 1'b1;
      bt_pre[3:0] <= 4'h1;
      bt_tgt[15:0] <= 16'h0003;
      bt_start <= 2'h1;
      @(posedge clk);
      bt_start <= 2'h0;
      wait_ev(0, 50, n);
      wait_ev(0, 50, n);
      cmp("bt0 period", 16'h8, n[15:0]);
      @(posedge clk);
      bt_stop <= 2'h1;
      @(posedge clk);
      bt_stop <= 2'h0;
      repeat (2) @(negedge clk);
      held = bt_count[15:0];
      repeat (5) @(negedge clk);
      cmp("bt0 running", 16'h0, bt_run[0]);
      cmp("bt0 held", held, bt_count[15:0]);
   endtask
   task automatic t_edge();
      int n;
      @(posedge clk);
      bt_tgt[31:16] <= 16'h0005;
      bt_start <= 2'h2;
      @(posedge clk);
      bt_start <= 2'h0;
      // five edges reach the terminal count, the sixth wraps it, the seventh counts again after the wrap
      fork
         u_far.toggle_tick(1, 7);
         wait_ev(1, 40, n);
      join
      repeat (6) @(negedge clk);
      cmp("bt1 edge event", 16'h1, 16'(n < 40));
      cmp("bt1 edge count", 16'h1, bt_count[31:16]);
      cmp("bt1 running", 16'h1, bt_run[1]);
   endtask
   task automatic t_rates();
      int n;
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         t2_sel <= 2'(s);
         t2_per <= 1'b1;
         t2_start <= 1'b1;
         @(posedge clk);
         t2_start <= 1'b0;
         wait_ev(2, 1300, n);
         wait_ev(2, 1300, n);
         if (s == 0)
            cmp("t2 fast gap ok", 16'h1, 16'(n == 1 || n == 2));
         else
            cmp("t2 tick gap", (s == 1) ? 16'h0014 : 16'h04E2, n[15:0]);
      end
      @(posedge clk);
      t2_stop <= 1'b1;
      @(posedge clk);
      t2_stop <= 1'b0;
      repeat (2) @(negedge clk);
      cmp("t2 running", 16'h0, t2_run);
   endtask
   task automatic t_compare();
      int n;
      @(posedge clk);
      t2_sel <= 2'h1;
      t2_per <= 1'b0;
      t2_tgt <= 16'h0004;
      ch_cmp[15:0] <= 16'h0002;
      ch_adc <= 4'h1;
      t2_start <= 1'b1;
      @(posedge clk);
      t2_start <= 1'b0;
      repeat (2) @(negedge clk);
      cmp("pwm0", 16'h1, ch_pwm[0]);
      wait_ev(3, 100, n);
      cmp("adc trigger", 16'h1, adc_trig);
      cmp("t2 count at match", 16'h3, t2_count);
      cmp("pwm0", 16'h0, ch_pwm[0]);
      wait_ev(2, 100, n);
      cmp("t2 end gap", 16'h0028, n[15:0]);
      cmp("t2 running", 16'h0, t2_run);
      cmp("t2 count", 16'h4, t2_count);
      repeat (30) @(negedge clk);
      cmp("adc hits", 16'h1, 16'(u_far.adc_hits));
   endtask
   task automatic t_capture();
      int n;
      // park the timer at a known count so every capture has a fixed expected value
      @(posedge clk);
      t2_sel <= 2'h1;
      t2_per <= 1'b0;
      t2_tgt <= 16'h0001;
      t2_start <= 1'b1;
      @(posedge clk);
      t2_start <= 1'b0;
      wait_ev(2, 100, n);
      cmp("t2 parked", 16'h1, t2_count);
      // second pulse meets a disarmed one-shot channel; the re-arm makes it periodic
      for (int k = 0; k < 4; k++) begin
         if (k == 2) begin
            @(posedge clk);
            ch_arm <= 4'h2;
            ch_per <= 4'h2;
            @(posedge clk);
            ch_arm <= 4'h0;
         end
         fork
            u_far.pulse_cap(1);
            wait_ev(4, 30, n);
         join
         cmp("cap1 event", (k == 1) ? 16'h0 : 16'h1, 16'(n < 30));
         cmp("cap1 value", 16'h0001, ch_capd[31:16]);
      end
      cmp("pwm1 capture", 16'h0, ch_pwm[1]);
      cmp("adc hits", 16'h1, 16'(u_far.adc_hits));
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      cmp("idle after reset", 16'h0, 16'({bt_run, t2_run, bt_count[15:0] != 0}));
      t_oneshot();
      t_periodic();
      t_edge();
      t_rates();
      t_compare();
      t_capture();
      test_done();
   end
endmodule // tb_sensor_engine_timers
